/* File: design/ahl_logger.sv */
/*
  Alarm history logger top: ten newest alarms with time stamps, repeat
  suppression, indexed browsing, clear command, single-owner arbitration.
  Assumes alarm strobes and operator commands are synchronous pulses; RST_IN
  is power-on reset only, alarm reset and main power loss do not reach it.
*/
// Function
// - keep the ten newest alarms, each with its code and time stamp
// - operating time counts one per 100 ms while both supplies on
// - a recorded alarm takes the current operating time as stamp
// - operating time counter does not overflow within about 13 years
// - same code stored again only if every stored entry of that code is more than one hour old
// - index 0 newest, 9 oldest, step up or down
// - empty slot reads as a distinct empty indication
// - alarm reset and main power removal leave the history unchanged
// - history empties only on the clear-history command; RST_IN also empties it
// - second interface running a function is refused with busy indication
`default_nettype none
module ahl_logger
  import ahl_pkg::*;
(
  // clock, reset, enable
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              CE_IN,
  // supplies and alarm events
  input  wire logic              CTRL_PWR_IN,
  input  wire logic              MAIN_PWR_IN,
  input  wire logic              ALARM_RESET_IN,
  input  wire logic              ALARM_VALID_IN,
  input  wire logic [CODE_W-1:0] ALARM_CODE_IN,
  // operator interfaces, one bit per interface
  input  wire logic [PORTS-1:0]  SHOW_START_IN,
  input  wire logic [PORTS-1:0]  CLEAR_START_IN,
  input  wire logic [PORTS-1:0]  EXIT_IN,
  input  wire logic [PORTS-1:0]  STEP_UP_IN,
  input  wire logic [PORTS-1:0]  STEP_DOWN_IN,
  // viewing outputs
  output logic [PORTS-1:0]       BUSY_ELSEWHERE_OUT,
  output logic [PORTS-1:0]       OWNER_OUT,
  output logic [IDX_W-1:0]       INDEX_OUT,
  output ahl_view_t              VIEW_OUT,
  output logic                   CLEAR_DONE_OUT,
  output logic [TIME_W-1:0]      OPTIME_OUT
);
  ahl_entry_t            hist [DEPTH];
  ahl_entry_t            next_hist [DEPTH];
  logic [DEPTH-1:0]      used;
  logic [DEPTH-1:0]      next_used;
  ahl_state_t            state;
  ahl_state_t            next_state;
  logic                  owner;
  logic                  next_owner;
  logic [IDX_W-1:0]      index;
  logic [IDX_W-1:0]      next_index;
  logic [PORTS-1:0]      refuse;
  logic [PORTS-1:0]      next_refuse;
  logic                  clr_done;
  logic                  next_clr_done;
  ahl_view_t             view;
  ahl_view_t             next_view;
  logic [TIME_W-1:0]     optime;
  logic                  accept;
  logic                  clear_now;

  // supply gating: main power loss only pauses time, never touches history
  ahl_optime u_optime (
    .clk    (CLK_IN),
    .rst    (RST_IN),
    .ce     (CE_IN),
    .run    (CTRL_PWR_IN & MAIN_PWR_IN),
    .optime (optime)
  );

  // true when code repeats a stored one whose stamp is within the hour
  function automatic logic recent_repeat(input ahl_entry_t e, input logic v,
                                         input logic [CODE_W-1:0] c,
                                         input logic [TIME_W-1:0] now);
    recent_repeat = v && (e.code == c) && ((now - e.stamp) <= HOUR_TICKS);
  endfunction : recent_repeat

  // repeat check against every stored entry of the same code
  always_comb begin
    accept = ALARM_VALID_IN;
    for (int i = 0; i < DEPTH; i++) begin
      if (recent_repeat(hist[i], used[i], ALARM_CODE_IN, optime)) begin
        accept = 1'b0;
      end
    end
  end

  // session arbiter: one interface owns a function at a time
  always_comb begin
    next_state    = state;
    next_owner    = owner;
    next_index    = index;
    next_refuse   = '0;
    next_clr_done = 1'b0;
    clear_now     = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (SHOW_START_IN[0] || CLEAR_START_IN[0]) begin
          next_owner  = 1'b0;
          next_state  = CLEAR_START_IN[0] ? ST_CLEAR : ST_SHOW;
          next_refuse = {SHOW_START_IN[1] | CLEAR_START_IN[1], 1'b0};
        end else if (SHOW_START_IN[1] || CLEAR_START_IN[1]) begin
          next_owner = 1'b1;
          next_state = CLEAR_START_IN[1] ? ST_CLEAR : ST_SHOW;
        end
        next_index = IDX_FIRST;
      end
      ST_SHOW: begin
        // other interface is refused while this session runs
        next_refuse[~owner] = SHOW_START_IN[~owner] | CLEAR_START_IN[~owner];
        if (EXIT_IN[owner]) begin
          next_state = ST_IDLE;
        end else if (STEP_UP_IN[owner] && index != IDX_LAST) begin
          next_index = index + 4'h1;
        end else if (STEP_DOWN_IN[owner] && index != IDX_FIRST) begin
          next_index = index - 4'h1;
        end
      end
      ST_CLEAR: begin
        next_refuse[~owner] = SHOW_START_IN[~owner] | CLEAR_START_IN[~owner];
        clear_now     = 1'b1;
        next_clr_done = 1'b1;
        next_state    = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // history shift register; alarm reset is not an input of this logic
  always_comb begin
    next_hist = hist;
    next_used = used;
    if (clear_now) begin
      next_used = '0;
    end else if (accept) begin
      // oldest falls off the end, newest lands in slot 0
      for (int i = DEPTH - 1; i > 0; i--) begin
        next_hist[i] = hist[i-1];
      end
      next_used         = {used[DEPTH-2:0], 1'b1};
      next_hist[0].code  = ALARM_CODE_IN;
      next_hist[0].stamp = optime;
    end
  end

  // registered view of the selected slot, updated on the same edge as the index
  always_comb begin
    next_view.valid = used[next_index];
    next_view.code  = used[next_index] ? hist[next_index].code : EMPTY_CODE;
    next_view.stamp = used[next_index] ? hist[next_index].stamp : '0;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state    <= ST_IDLE;
      owner    <= 1'b0;
      index    <= '0;
      refuse   <= '0;
      clr_done <= 1'b0;
      view     <= '{valid: 1'b0, code: EMPTY_CODE, stamp: '0};
    end else if (CE_IN) begin
      state    <= next_state;
      owner    <= next_owner;
      index    <= next_index;
      refuse   <= next_refuse;
      clr_done <= next_clr_done;
      view     <= next_view;
    end
  end

  // history storage; RST_IN models a first power-up, not an alarm reset
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      used <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        hist[i] <= '0;
      end
    end else if (CE_IN) begin
      used <= next_used;
      hist <= next_hist;
    end
  end

  // outputs
  assign BUSY_ELSEWHERE_OUT = refuse;
  assign OWNER_OUT          = (state == ST_IDLE) ? 2'h0 : (owner ? 2'h2 : 2'h1);
  assign INDEX_OUT          = index;
  assign VIEW_OUT           = view;
  assign CLEAR_DONE_OUT     = clr_done;
  assign OPTIME_OUT         = optime;
endmodule : ahl_logger
`default_nettype wire

/* File: design/ahl_optime.sv */
/*
  Operating-time counter: counts 100 ms steps while both supplies are on.
  Assumes supply flags are synchronous to CLK_IN.
*/
`default_nettype none
module ahl_optime
  import ahl_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // supplies
  input  wire logic              run,
  // time
  output logic [TIME_W-1:0]      optime
);
  logic [TICK_CNT_W-1:0] div;
  logic [TICK_CNT_W-1:0] next_div;
  logic [TIME_W-1:0]     next_optime;

  // prescaler and step counter; no overflow within 13 years
  always_comb begin
    next_div    = div;
    next_optime = optime;
    if (run) begin
      if (div == TICK_CNT_W'(TICK_CYCLES - 1)) begin
        next_div    = '0;
        next_optime = optime + 32'h1;
      end else begin
        next_div = div + 24'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div    <= '0;
      optime <= '0;
    end else if (ce) begin
      div    <= next_div;
      optime <= next_optime;
    end
  end
endmodule : ahl_optime
`default_nettype wire

/* File: design/ahl_pkg.sv */
/*
  Package for the alarm history logger: widths, depths, timing counts,
  the empty-entry code and the packed carriers shared by the design files.
  Assumes a 125 MHz clock and synchronous inputs.
*/
`default_nettype none
package ahl_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned TICK_MS        = 100;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_CNT_W     = 24;
  // about 13 years at 100 ms per step needs 32 bits (2^32 * 0.1 s = 13.6 years)
  localparam int unsigned TIME_W         = 32;
  localparam int unsigned HOUR_S         = 3600;
  localparam logic [TIME_W-1:0] HOUR_TICKS = TIME_W'(HOUR_S * 1000 / TICK_MS);
  // history geometry
  localparam int unsigned DEPTH          = 10;
  localparam int unsigned IDX_W          = 4;
  localparam logic [IDX_W-1:0] IDX_LAST  = 4'h9;
  localparam logic [IDX_W-1:0] IDX_FIRST = 4'h0;
  localparam int unsigned CODE_W         = 12;
  // code shown for an unused slot
  localparam logic [CODE_W-1:0] EMPTY_CODE = 12'hfff;
  // operator interfaces
  localparam int unsigned PORTS          = 2;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [TIME_W-1:0] stamp;
  } ahl_entry_t;

  typedef struct packed {
    logic valid;
    logic [CODE_W-1:0] code;
    logic [TIME_W-1:0] stamp;
  } ahl_view_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHOW  = 3'b010,
    ST_CLEAR = 3'b100
  } ahl_state_t;
endpackage : ahl_pkg
`default_nettype wire

/* File: testbench/ahl_logger_checker.sv */
/* Assertion checker for ahl_logger, bound to every instance.
   Assumes CE_IN stays high while operator starts are issued. */
`default_nettype none
module ahl_chk
  import ahl_pkg::*;
(
  // clock and reset
  input wire logic              CLK_IN,
  input wire logic              RST_IN,
  input wire logic              CE_IN,
  // operator side
  input wire logic [PORTS-1:0]  SHOW_START_IN,
  input wire logic [PORTS-1:0]  CLEAR_START_IN,
  input wire logic [PORTS-1:0]  BUSY_ELSEWHERE_OUT,
  input wire logic [PORTS-1:0]  OWNER_OUT,
  input wire logic [IDX_W-1:0]  INDEX_OUT,
  input wire ahl_view_t         VIEW_OUT,
  input wire logic              CLEAR_DONE_OUT,
  input wire logic [TIME_W-1:0] OPTIME_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // a start only counts while nobody owns the viewer
  logic idle;
  assign idle = CE_IN && (OWNER_OUT == 2'b00);
  // clear request, then done two edges on
  sequence s_clr_req;
    idle && CLEAR_START_IN[0] && !SHOW_START_IN[0];
  endsequence
  sequence s_clr_end;
    ##2 CLEAR_DONE_OUT;
  endsequence
  AST_CLR: assert property (s_clr_req |-> s_clr_end) else $error("clear not done");
  AST_WIPE: assert property (CLEAR_DONE_OUT |=> !VIEW_OUT.valid) else $error("entry after clear");
  AST_OWN: assert property (idle && SHOW_START_IN[0] |=> OWNER_OUT == 2'b01) else $error("no owner");
  AST_IDX0: assert property (idle && SHOW_START_IN[0] |=> INDEX_OUT == IDX_FIRST) else $error("bad index");
  AST_BUSY: assert property (CE_IN && OWNER_OUT == 2'b01 && SHOW_START_IN[1] |=> BUSY_ELSEWHERE_OUT[1])
    else $error("no refusal");
  AST_ONE: assert property (OWNER_OUT != 2'b11) else $error("two owners");
  AST_MAX: assert property (INDEX_OUT <= IDX_LAST) else $error("index range");
  AST_EMPTY: assert property (!VIEW_OUT.valid |-> VIEW_OUT.code == EMPTY_CODE) else $error("empty code");
  AST_MONO: assert property (OPTIME_OUT >= $past(OPTIME_OUT)) else $error("time went back");
endmodule : ahl_chk
bind ahl_logger ahl_chk u_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN),
  .SHOW_START_IN(SHOW_START_IN), .CLEAR_START_IN(CLEAR_START_IN),
  .BUSY_ELSEWHERE_OUT(BUSY_ELSEWHERE_OUT), .OWNER_OUT(OWNER_OUT),
  .INDEX_OUT(INDEX_OUT), .VIEW_OUT(VIEW_OUT),
  .CLEAR_DONE_OUT(CLEAR_DONE_OUT), .OPTIME_OUT(OPTIME_OUT));
`default_nettype wire

/* File: testbench/ahl_panel.sv */
/* Operator panel model: key pulses for both operator interfaces.
   Assumes the caller waits for one press to end before the next. */
`default_nettype none
module ahl_panel
  import ahl_pkg::*;
(
  // clock
  input  wire logic            clk_in,
  // key pulses, bit per interface
  output var logic [PORTS-1:0] show_out,
  output var logic [PORTS-1:0] clear_out,
  output var logic [PORTS-1:0] exit_out,
  output var logic [PORTS-1:0] up_out,
  output var logic [PORTS-1:0] down_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // keys idle at power up
  initial begin
    {show_out, clear_out, exit_out, up_out, down_out} = '0;
  end
  // one key, one cycle wide; idle cycle between presses
  task automatic press(input int k, input int p);
    @(posedge clk_in);
    case (k)
      0: show_out[p] <= 1'b1;
      1: clear_out[p] <= 1'b1;
      2: exit_out[p] <= 1'b1;
      3: up_out[p] <= 1'b1;
      default: down_out[p] <= 1'b1;
    endcase
    @(posedge clk_in);
    {show_out, clear_out, exit_out, up_out, down_out} <= '0;
  endtask : press
endmodule : ahl_panel
`default_nettype wire

/* File: testbench/testbench.sv */
/* Self-checking bench for ahl_logger with the panel model.
   Assumes no run reaches one 100 ms tick, so stamps stay zero. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ahl_pkg::*;
  logic clk = 1'b0;
  logic ce = 1'b1;
  logic rst = 1'b1;
  logic mpwr = 1'b1;
  logic arst = 1'b0;
  logic avalid = 1'b0;
  logic [CODE_W-1:0] acode = '0;
  logic [PORTS-1:0] show, clr, ext, up, dn, busy, own;
  logic [IDX_W-1:0] idx;
  ahl_view_t view;
  logic done;
  logic [TIME_W-1:0] optime;
  int n_mismatch = 0;
  int total_checks = 0;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
  // 125 MHz
  initial forever #4 clk = ~clk;
  ahl_panel u_panel (.clk_in(clk), .show_out(show), .clear_out(clr), .exit_out(ext), .up_out(up),
    .down_out(dn));
  ahl_logger DUT (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .CTRL_PWR_IN(1'b1), .MAIN_PWR_IN(mpwr),
    .ALARM_RESET_IN(arst), .ALARM_VALID_IN(avalid), .ALARM_CODE_IN(acode), .SHOW_START_IN(show),
    .CLEAR_START_IN(clr), .EXIT_IN(ext), .STEP_UP_IN(up), .STEP_DOWN_IN(dn),
    .BUSY_ELSEWHERE_OUT(busy), .OWNER_OUT(own), .INDEX_OUT(idx), .VIEW_OUT(view),
    .CLEAR_DONE_OUT(done), .OPTIME_OUT(optime));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // one-cycle alarm strobe
  task automatic alarm(input logic [CODE_W-1:0] c);
    @(posedge clk);
    avalid <= 1'b1;
    acode <= c;
    @(posedge clk);
    avalid <= 1'b0;
  endtask : alarm
  // look at the viewer once outputs settle
  task automatic see(input logic [IDX_W-1:0] i, input logic v, input logic [CODE_W-1:0] c);
    @(negedge clk);
    `CHK(idx, i)
    `CHK({view.valid, view.code}, {v, c})
    `CHK(view.stamp, 32'h0)
  endtask : see
  task automatic t_empty;
    u_panel.press(0, 0);
    see(4'h0, 1'b0, EMPTY_CODE);
    for (int i = 1; i <= DEPTH; i++) begin
      u_panel.press(3, 0);
      see((i < DEPTH) ? IDX_W'(i) : IDX_LAST, 1'b0, EMPTY_CODE);
    end
    u_panel.press(2, 0);
    $display("t_empty done");
  endtask : t_empty
  // eleven alarms: oldest falls out
  task automatic t_fill;
    for (int c = 1; c <= 11; c++) alarm(CODE_W'(c));
    u_panel.press(0, 0);
    for (int i = 0; i < DEPTH; i++) begin
      see(IDX_W'(i), 1'b1, CODE_W'(11 - i));
      u_panel.press(3, 0);
    end
    see(IDX_LAST, 1'b1, 12'h002);
    u_panel.press(4, 0);
    see(4'h8, 1'b1, 12'h003);
    $display("t_fill done");
  endtask : t_fill
  // second interface refused while first owns
  task automatic t_busy;
    u_panel.press(0, 1);
    @(negedge clk);
    `CHK({busy, own}, {2'b10, 2'b01})
    u_panel.press(2, 0);
    $display("t_busy done");
  endtask : t_busy
  // repeat within the hour dropped, new code kept
  task automatic t_repeat;
    alarm(12'h005);
    alarm(12'h00c);
    u_panel.press(0, 0);
    see(4'h0, 1'b1, 12'h00c);
    u_panel.press(3, 0);
    see(4'h1, 1'b1, 12'h00b);
    u_panel.press(2, 0);
    $display("t_repeat done");
  endtask : t_repeat
  // alarm reset and main power loss keep history
  task automatic t_keep;
    @(posedge clk);
    arst <= 1'b1;
    mpwr <= 1'b0;
    @(posedge clk);
    arst <= 1'b0;
    // enable low: a new alarm must not land
    ce <= 1'b0;
    alarm(12'h00e);
    @(posedge clk);
    ce <= 1'b1;
    u_panel.press(0, 0);
    see(4'h0, 1'b1, 12'h00c);
    `CHK(optime, 32'h0)
    @(posedge clk);
    mpwr <= 1'b1;
    u_panel.press(2, 0);
    $display("t_keep done");
  endtask : t_keep
  // clear, slot 0 then reads empty; old code then stored again
  task automatic t_clear;
    u_panel.press(1, 0);
    // done pulses one edge after the clear state
    @(posedge clk);
    @(negedge clk);
    `CHK(done, 1'b1)
    u_panel.press(0, 0);
    see(4'h0, 1'b0, EMPTY_CODE);
    u_panel.press(2, 0);
    alarm(12'h005);
    u_panel.press(0, 0);
    see(4'h0, 1'b1, 12'h005);
    $display("t_clear done");
  endtask : t_clear
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_empty();
    t_fill();
    t_busy();
    t_repeat();
    t_keep();
    t_clear();
    report_and_stop();
  end
  // watchdog, well beyond the roughly 130 cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
